// >>> exec_core_regs.vh
`ifndef EXEC_CORE_REGS_VH
`define EXEC_CORE_REGS_VH
// ----------------------------------------
// Opcode masks and match patterns
// ----------------------------------------
`define OPM_CP 16'hFC00
`define OPV_CP 16'h1400
`define OPV_CPC 16'h0400
`define OPV_MOV 16'h2C00
`define OPM_IMM 16'hF000
`define OPV_CPI 16'h3000
`define OPV_LDI 16'hE000
`define OPM_SKR 16'hFC08
`define OPV_SKR 16'hFC00
`define OPM_SKIO 16'hFD00
`define OPV_SKIO 16'h9900
`define OPM_BR 16'hF800
`define OPV_BR 16'hF000
`define OPM_PTR 16'hFC00
`define OPV_PTR 16'h9000
`define OPM_DISP 16'hD000
`define OPV_DISP 16'h8000
`define OPM_DIR 16'hFC0F
`define OPV_DIR 16'h9000
`define OPM_JMP 16'hFE0C
`define OPV_JMP 16'h940C
// ----------------------------------------
// Pointer mode nibble codes
// ----------------------------------------
`define PM_DIRECT 4'h0
`define PM_Z_INC 4'h1
`define PM_Z_DEC 4'h2
`define PM_Y_INC 4'h9
`define PM_Y_DEC 4'hA
`define PM_X 4'hC
`define PM_X_INC 4'hD
`define PM_X_DEC 4'hE
// ----------------------------------------
// Pointer pair low-byte register indices
// ----------------------------------------
`define PTR_X 5'h1A
`define PTR_Y 5'h1C
`define PTR_Z 5'h1E
// ----------------------------------------
// Status flag bit positions
// ----------------------------------------
`define FL_C 0
`define FL_Z 1
`define FL_N 2
`define FL_V 3
`define FL_S 4
`define FL_H 5
`define FL_T 6
`define FL_I 7
// ----------------------------------------
// Reset values and steps
// ----------------------------------------
`define FLAGS_RESET 8'h00
`define REG_RESET 8'h00
`define PC_RESET 16'h0000
`define ADDR_RESET 16'h0000
`define STEP_ONE 16'h0001
`define STEP_TWO 16'h0002
`define STEP_THREE 16'h0003
`define STALL_ONE 2'h1
`define STALL_TWO 2'h2
`endif

// >>> compare_sub.v
`timescale 1ns/1ps
// ----------------------------------------
// Compare subtractor with flag outputs
// ----------------------------------------
module compare_sub (
  input wire [7:0] op_a,
  input wire [7:0] op_b,
  input wire carry_in,
  input wire keep_zero,
  input wire zero_prev,
  output wire flag_c,
  output wire flag_z,
  output wire flag_n,
  output wire flag_v,
  output wire flag_s,
  output wire flag_h
);
  // Nine-bit difference, borrow in the top bit
  wire [8:0] diff;
  // Eight-bit result, never written back
  wire [7:0] res;
  assign diff = {1'b0, op_a} - {1'b0, op_b} - {8'h00, carry_in};
  assign res = diff[7:0];
  // Borrow out of bit 7
  assign flag_c = diff[8];
  // Carry form only keeps zero set across a chain
  assign flag_z = (res == 8'h00) & (~keep_zero | zero_prev);
  assign flag_n = res[7];
  // Two's complement overflow of the subtraction
  assign flag_v = (op_a[7] & ~op_b[7] & ~res[7]) | (~op_a[7] & op_b[7] & res[7]);
  assign flag_s = flag_n ^ flag_v;
  // Borrow out of bit 3
  assign flag_h = (~op_a[3] & op_b[3]) | (op_b[3] & res[3]) | (res[3] & ~op_a[3]);
endmodule

// >>> exec_core.v
`timescale 1ns/1ps
`include "exec_core_regs.vh"
module exec_core #(
  parameter PC_WIDTH = 16
) (
  input wire core_clk,
  input wire reset_n,
  input wire [15:0] instr_word,
  input wire [15:0] instr_next,
  input wire [255:0] io_low_regs,
  input wire [7:0] data_rdata,
  input wire [4:0] dbg_sel,
  output reg [PC_WIDTH-1:0] prog_addr,
  output reg [15:0] data_addr,
  output reg [7:0] data_wdata,
  output reg data_we,
  output reg data_re,
  output reg [7:0] status_flags,
  output reg [7:0] dbg_data,
  output reg busy,
  output reg unsupported_op
);
  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam ST_EXEC = 4'b0001;
  localparam ST_LOAD = 4'b0010;
  localparam ST_STORE = 4'b0100;
  localparam ST_STALL = 4'b1000;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // General working registers
  reg [7:0] gpr [0:31];
  // Sequencer state
  reg [3:0] state;
  // Remaining flush cycles
  reg [1:0] stall_cnt;
  // Destination of a pending load
  reg [4:0] load_dest;
  // Loop index for reset
  integer i;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Masked opcode match, used for every class
  function op_is;
    input [15:0] word;
    input [15:0] mask;
    input [15:0] val;
    begin
      op_is = ((word & mask) == val);
    end
  endfunction

  // Two-word instruction detection
  function is_two_word;
    input [15:0] word;
    begin
      is_two_word = op_is(word, `OPM_DIR, `OPV_DIR) | op_is(word, `OPM_DIR, `OPV_DIR | 16'h0200) |
        op_is(word, `OPM_JMP, `OPV_JMP);
    end
  endfunction

  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  // Destination or source register
  wire [4:0] f_d;
  // Second register operand
  wire [4:0] f_r;
  // Upper-half register for immediates
  wire [4:0] f_dh;
  // Eight-bit immediate
  wire [7:0] f_k;
  // Bit or flag selector
  wire [2:0] f_b;
  // I/O register address
  wire [4:0] f_io;
  // Relative branch offset, sign extended
  wire [15:0] f_off;
  // Displacement
  wire [5:0] f_q;
  assign f_d = instr_word[8:4];
  assign f_r = {instr_word[9], instr_word[3:0]};
  assign f_dh = {1'b1, instr_word[7:4]};
  assign f_k = {instr_word[11:8], instr_word[3:0]};
  assign f_b = instr_word[2:0];
  assign f_io = instr_word[7:3];
  assign f_off = {{9{instr_word[9]}}, instr_word[9:3]};
  assign f_q = {instr_word[13], instr_word[11:10], instr_word[2:0]};

  // ----------------------------------------
  // Class decode
  // ----------------------------------------
  wire dec_cp;
  wire dec_cpc;
  wire dec_cpi;
  wire dec_mov;
  wire dec_ldi;
  wire dec_skr;
  wire dec_skio;
  wire dec_br;
  wire dec_ptr;
  wire dec_disp;
  assign dec_cp = op_is(instr_word, `OPM_CP, `OPV_CP);
  assign dec_cpc = op_is(instr_word, `OPM_CP, `OPV_CPC);
  assign dec_cpi = op_is(instr_word, `OPM_IMM, `OPV_CPI);
  assign dec_mov = op_is(instr_word, `OPM_CP, `OPV_MOV);
  assign dec_ldi = op_is(instr_word, `OPM_IMM, `OPV_LDI);
  assign dec_skr = op_is(instr_word, `OPM_SKR, `OPV_SKR);
  assign dec_skio = op_is(instr_word, `OPM_SKIO, `OPV_SKIO);
  assign dec_br = op_is(instr_word, `OPM_BR, `OPV_BR);
  assign dec_ptr = op_is(instr_word, `OPM_PTR, `OPV_PTR);
  assign dec_disp = op_is(instr_word, `OPM_DISP, `OPV_DISP);

  // ----------------------------------------
  // Compare datapath
  // ----------------------------------------
  wire [7:0] cmp_b;
  wire c_c;
  wire c_z;
  wire c_n;
  wire c_v;
  wire c_s;
  wire c_h;
  // Immediate form compares an upper register with K
  assign cmp_b = dec_cpi ? f_k : gpr[f_r];

  // Shared subtractor, result discarded
  compare_sub u_cmp (
    .op_a(dec_cpi ? gpr[f_dh] : gpr[f_d]),
    .op_b(cmp_b),
    .carry_in(dec_cpc & status_flags[`FL_C]),
    .keep_zero(dec_cpc),
    .zero_prev(status_flags[`FL_Z]),
    .flag_c(c_c),
    .flag_z(c_z),
    .flag_n(c_n),
    .flag_v(c_v),
    .flag_s(c_s),
    .flag_h(c_h)
  );

  // ----------------------------------------
  // Skip and branch conditions
  // ----------------------------------------
  // Byte of the addressed I/O register
  wire [7:0] io_byte;
  // Tested bit of a skip
  wire skip_bit;
  // Skip taken this cycle
  wire skip_go;
  // Flag under test for a branch
  wire br_flag;
  // Branch taken this cycle
  wire br_go;
  // Relative branch target
  wire [15:0] br_target;
  assign io_byte = io_low_regs[{f_io, 3'b000} +: 8];
  assign skip_bit = dec_skio ? io_byte[f_b] : gpr[f_d][f_b];
  // Bit 9 selects the one-variant of both skip pairs
  assign skip_go = (dec_skr | dec_skio) & (skip_bit == instr_word[9]);
  // Sign flag is formed live from negative and overflow
  assign br_flag = (f_b == `FL_S) ? (status_flags[`FL_N] ^ status_flags[`FL_V]) : status_flags[f_b];
  // Bit 10 clear means the flag-one form
  assign br_go = dec_br & (br_flag == ~instr_word[10]);
  assign br_target = prog_addr + f_off + `STEP_ONE;

  // ----------------------------------------
  // Pointer addressing
  // ----------------------------------------
  // Mode nibble of the pointer group
  wire [3:0] pmode;
  // Low register of the selected pair
  reg [4:0] pidx;
  // Current pointer value
  wire [15:0] pval;
  // Effective data address
  reg [15:0] eff_addr;
  // Updated pointer value
  reg [15:0] next_ptr;
  // Pointer must be written back
  reg ptr_upd;
  // Group access is a legal mode
  reg mem_ok;
  assign pmode = instr_word[3:0];
  assign pval = {gpr[pidx | 5'h01], gpr[pidx]};

  // Address and pointer update for loads and stores
  always @* begin
    pidx = `PTR_Z;
    eff_addr = pval;
    next_ptr = pval;
    ptr_upd = 1'b0;
    mem_ok = 1'b0;
    if (dec_disp) begin
      // Displacement never touches the pointer
      pidx = instr_word[3] ? `PTR_Y : `PTR_Z;
      eff_addr = pval + {10'h000, f_q};
      mem_ok = 1'b1;
    end else if (dec_ptr) begin
      if (pmode[3:2] == 2'b11) begin
        pidx = `PTR_X;
      end else if (pmode[3]) begin
        pidx = `PTR_Y;
      end else begin
        pidx = `PTR_Z;
      end
      case (pmode)
        `PM_DIRECT: begin
          eff_addr = instr_next;
          mem_ok = 1'b1;
        end
        `PM_X: begin
          mem_ok = 1'b1;
        end
        `PM_X_INC, `PM_Y_INC, `PM_Z_INC: begin
          // Access old address, bump after
          next_ptr = pval + `STEP_ONE;
          ptr_upd = 1'b1;
          mem_ok = 1'b1;
        end
        `PM_X_DEC, `PM_Y_DEC, `PM_Z_DEC: begin
          // Decrement first, access new address
          next_ptr = pval - `STEP_ONE;
          eff_addr = pval - `STEP_ONE;
          ptr_upd = 1'b1;
          mem_ok = 1'b1;
        end
        default: begin
          mem_ok = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer and register file
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 32; i = i + 1) begin
        gpr[i] <= `REG_RESET;
      end
      state <= ST_EXEC;
      stall_cnt <= 2'h0;
      load_dest <= 5'h00;
      prog_addr <= `PC_RESET;
      data_addr <= `ADDR_RESET;
      data_wdata <= `REG_RESET;
      data_we <= 1'b0;
      data_re <= 1'b0;
      status_flags <= `FLAGS_RESET;
      dbg_data <= `REG_RESET;
      busy <= 1'b0;
      unsupported_op <= 1'b0;
    end else begin
      // Strobes last one cycle
      data_we <= 1'b0;
      data_re <= 1'b0;
      unsupported_op <= 1'b0;
      dbg_data <= gpr[dbg_sel];
      case (state)
        ST_EXEC: begin
          if (dec_cp | dec_cpc | dec_cpi) begin
            // Flags only, operands untouched
            status_flags[`FL_C] <= c_c;
            status_flags[`FL_Z] <= c_z;
            status_flags[`FL_N] <= c_n;
            status_flags[`FL_V] <= c_v;
            status_flags[`FL_S] <= c_s;
            status_flags[`FL_H] <= c_h;
            prog_addr <= prog_addr + `STEP_ONE;
          end else if (dec_mov) begin
            gpr[f_d] <= gpr[f_r];
            prog_addr <= prog_addr + `STEP_ONE;
          end else if (dec_ldi) begin
            gpr[f_dh] <= f_k;
            prog_addr <= prog_addr + `STEP_ONE;
          end else if (dec_skr | dec_skio) begin
            if (skip_go) begin
              // Jump over one or two words, flush as many cycles
              if (is_two_word(instr_next)) begin
                prog_addr <= prog_addr + `STEP_THREE;
                stall_cnt <= `STALL_TWO;
              end else begin
                prog_addr <= prog_addr + `STEP_TWO;
                stall_cnt <= `STALL_ONE;
              end
              state <= ST_STALL;
              busy <= 1'b1;
            end else begin
              prog_addr <= prog_addr + `STEP_ONE;
            end
          end else if (dec_br) begin
            if (br_go) begin
              // Taken branch costs one flush cycle
              prog_addr <= br_target;
              stall_cnt <= `STALL_ONE;
              state <= ST_STALL;
              busy <= 1'b1;
            end else begin
              prog_addr <= prog_addr + `STEP_ONE;
            end
          end else if ((dec_ptr | dec_disp) & mem_ok) begin
            data_addr <= eff_addr;
            if (ptr_upd) begin
              gpr[pidx] <= next_ptr[7:0];
              gpr[pidx | 5'h01] <= next_ptr[15:8];
            end
            if (dec_ptr & (pmode == `PM_DIRECT)) begin
              // Absolute address uses the second word
              prog_addr <= prog_addr + `STEP_TWO;
            end else begin
              prog_addr <= prog_addr + `STEP_ONE;
            end
            if (instr_word[9]) begin
              // Store issues its write now
              data_wdata <= gpr[f_d];
              data_we <= 1'b1;
              state <= ST_STORE;
            end else begin
              // Load captures data next cycle
              data_re <= 1'b1;
              load_dest <= f_d;
              state <= ST_LOAD;
            end
            busy <= 1'b1;
          end else begin
            // Outside this unit: report and step on
            unsupported_op <= 1'b1;
            prog_addr <= prog_addr + `STEP_ONE;
          end
        end
        ST_LOAD: begin
          // Second clock of a read
          gpr[load_dest] <= data_rdata;
          state <= ST_EXEC;
          busy <= 1'b0;
        end
        ST_STORE: begin
          // Second clock of a write
          state <= ST_EXEC;
          busy <= 1'b0;
        end
        ST_STALL: begin
          // Flush cycles after a skip or taken branch
          stall_cnt <= stall_cnt - 2'h1;
          if (stall_cnt == `STALL_ONE) begin
            state <= ST_EXEC;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= ST_EXEC;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> exec_core_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port-level checker for the execution core
// ----------------------------------------
module exec_core_checker #(
  parameter PC_WIDTH = 16
) (
  input wire core_clk,
  input wire reset_n,
  input wire [15:0] instr_word,
  input wire [15:0] instr_next,
  input wire [255:0] io_low_regs,
  input wire [7:0] data_rdata,
  input wire [4:0] dbg_sel,
  input wire [PC_WIDTH-1:0] prog_addr,
  input wire [15:0] data_addr,
  input wire [7:0] data_wdata,
  input wire data_we,
  input wire data_re,
  input wire [7:0] status_flags,
  input wire [7:0] dbg_data,
  input wire busy,
  input wire unsupported_op
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Decode of the watched instruction classes
  // ----------------------------------------
  wire run = !busy; // Core accepts the word on this edge
  wire is_cmp = (instr_word & 16'hF000) == 16'h3000 || (instr_word & 16'hEC00) == 16'h0400; // Three compares
  wire is_mov = (instr_word & 16'hFC00) == 16'h2C00 || (instr_word & 16'hF000) == 16'hE000; // Copy or constant
  wire is_br = (instr_word & 16'hF800) == 16'hF000; // Flag branches
  wire br_go = status_flags[instr_word[2:0]] != instr_word[10]; // Selected flag matches the variant
  wire [PC_WIDTH-1:0] br_tgt = prog_addr + {{(PC_WIDTH-7){instr_word[9]}}, instr_word[9:3]} + PC_WIDTH'(1);
  wire ok_mode = instr_word[3:0] inside {4'h0, 4'h1, 4'h2, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE}; // Legal modes
  wire is_ld = ((instr_word & 16'hFE00) == 16'h9000 && ok_mode) || (instr_word & 16'hD200) == 16'h8000;
  wire is_st = ((instr_word & 16'hFE00) == 16'h9200 && ok_mode) || (instr_word & 16'hD200) == 16'h8200;
  wire is_sio = (instr_word & 16'hFD00) == 16'h9900; // I/O bit skips
  wire sio_go = io_low_regs[{instr_word[7:3], instr_word[2:0]}] == instr_word[9]; // Skip condition
  wire two = (instr_next & 16'hFC0F) == 16'h9000 || (instr_next & 16'hFE0C) == 16'h940C; // Two-word follower
  // ----------------------------------------
  // Steps of a two-clock memory access
  // ----------------------------------------
  sequence s_mem(sig);
    sig && busy ##1 !sig && !busy;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_cmp_no_store: assert property (run && is_cmp |=> !data_we && !busy && prog_addr == $past(prog_addr) + 1)
    else $error("compare wrote memory or did not step by one");
  a_branch_taken: assert property (run && is_br && br_go |=> prog_addr == $past(br_tgt) && busy ##1 !busy)
    else $error("taken branch target or timing wrong");
  a_branch_idle: assert property (run && is_br && !br_go |=> !busy && prog_addr == $past(prog_addr) + 1)
    else $error("untaken branch did not fall through in one clock");
  a_branch_flags: assert property (run && is_br |=> $stable(status_flags))
    else $error("branch changed the flags");
  a_move_flags: assert property (run && is_mov |=> $stable(status_flags) && !busy && !data_we)
    else $error("copy or constant load changed flags or took too long");
  a_load_steps: assert property (run && is_ld |=> s_mem(data_re))
    else $error("memory read not a two clock access");
  a_store_steps: assert property (run && is_st |=> s_mem(data_we))
    else $error("memory write not a two clock access");
  a_io_skip: assert property (run && is_sio && sio_go |=> busy && prog_addr == $past(prog_addr) + ($past(two) ? 3 : 2))
    else $error("I/O bit skip distance wrong");
  a_io_noskip: assert property (run && is_sio && !sio_go |=> !busy && prog_addr == $past(prog_addr) + 1)
    else $error("I/O bit skip taken when bit did not match");
endmodule

bind exec_core exec_core_checker #(.PC_WIDTH(PC_WIDTH)) u_exec_core_checker (
  .core_clk(core_clk), .reset_n(reset_n), .instr_word(instr_word), .instr_next(instr_next),
  .io_low_regs(io_low_regs), .data_rdata(data_rdata), .dbg_sel(dbg_sel), .prog_addr(prog_addr),
  .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we), .data_re(data_re),
  .status_flags(status_flags), .dbg_data(dbg_data), .busy(busy), .unsupported_op(unsupported_op)
);

// >>> exec_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Program and data memory beside the core
// ----------------------------------------
module exec_mem_model (
  input wire core_clk,
  input wire [15:0] prog_addr,
  output wire [15:0] instr_word,
  output wire [15:0] instr_next,
  input wire [15:0] data_addr,
  input wire [7:0] data_wdata,
  input wire data_we,
  input wire data_re,
  output wire [7:0] data_rdata
);
  reg [15:0] pmem [0:63]; // Program words
  reg [7:0] dmem [0:511]; // Data bytes
  reg [7:0] last = 8'h00; // Last byte handed out
  integer i;
  // Clear both memories before the bench loads its program
  initial begin
    for (i = 0; i < 512; i = i + 1) begin
      dmem[i] = 8'h00;
      if (i < 64) pmem[i] = 16'h0000;
    end
  end
  assign instr_word = pmem[prog_addr[5:0]];
  assign instr_next = pmem[prog_addr[5:0] + 6'h01];
  // Outside a read the bus shows no stale byte, only its inverse
  assign data_rdata = data_re ? dmem[data_addr[8:0]] : ~last;
  // Capture writes and remember what was last read
  always @(posedge core_clk) begin
    if (data_re) last <= dmem[data_addr[8:0]];
    if (data_we) dmem[data_addr[8:0]] <= data_wdata;
  end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench for the execution core
// ----------------------------------------
module testbench;
  reg core_clk = 1'b0; // System clock
  reg reset_n = 1'b0; // Active-low reset
  reg [255:0] io_low_regs = 256'h080000000000; // I/O register 5 has bit 3 set
  reg [4:0] dbg_sel = 5'h00; // Observed register
  wire [15:0] instr_word, instr_next, data_addr, prog_addr;
  wire [7:0] data_rdata, data_wdata, status_flags, dbg_data;
  wire data_we, data_re, busy, unsupported_op;
  integer fails = 0; // Mismatch count
  integer checks_done = 0; // Comparison count
  integer cyc = 0; // Edges since reset release
  integer unsup = 0; // Stepped-over unknown words
  integer i;
  // Program: pointer store/load, copy, compares, branches, skips, direct read, displacement read,
  // pre-decrement store, post-increment load, unknown word, carry compare, alias branches over traps, self loop
  reg [15:0] prog [0:43] = '{16'hE1A0, 16'hE0B1, 16'hE50A, 16'h930D, 16'h911E, 16'h2F21, 16'h352A, 16'hF009,
    16'hEF3F, 16'h352B, 16'hF009, 16'hFF21, 16'h9130, 16'h0200, 16'h992B, 16'h9B2B, 16'hEF3F, 16'hE333,
    16'h9140, 16'h0110, 16'h1723, 16'hE0C0, 16'hE0D1, 16'h8958, 16'h933A, 16'h9161, 16'h0C00, 16'h160A,
    16'h0710, 16'hF008, 16'hEE7E, 16'hF00A, 16'hEE7E, 16'hF00C, 16'hEE7E, 16'hF00D, 16'hEE7E, 16'hF40B,
    16'hEE7E, 16'hF40F, 16'hEE7E, 16'hF40C, 16'hE787, 16'hF7FE};
  always #5 core_clk = ~core_clk;
  // Count edges and unknown-word pulses while running
  always @(posedge core_clk) begin
    if (reset_n) cyc <= cyc + 1;
    if (unsupported_op === 1'b1) unsup <= unsup + 1;
  end
  exec_core #(.PC_WIDTH(16)) u_exec_core (.core_clk(core_clk), .reset_n(reset_n), .instr_word(instr_word),
    .instr_next(instr_next), .io_low_regs(io_low_regs), .data_rdata(data_rdata), .dbg_sel(dbg_sel),
    .prog_addr(prog_addr), .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we), .data_re(data_re),
    .status_flags(status_flags), .dbg_data(dbg_data), .busy(busy), .unsupported_op(unsupported_op));
  exec_mem_model u_exec_mem_model (.core_clk(core_clk), .prog_addr(prog_addr), .instr_word(instr_word),
    .instr_next(instr_next), .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we),
    .data_re(data_re), .data_rdata(data_rdata));
  // ----------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------
  task chk8(input [127:0] name, input [7:0] exp, input [7:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task chk16(input [127:0] name, input [15:0] exp, input [15:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // Read a general register through the observation port and compare it
  task reg_chk(input [127:0] name, input [4:0] idx, input [7:0] exp);
    begin
      @(negedge core_clk);
      dbg_sel = idx;
      @(negedge core_clk);
      chk8(name, exp, dbg_data);
    end
  endtask
  // Wait, bounded, until the program counter reaches a word
  task wait_pc(input [15:0] t);
    integer n;
    begin
      n = 0;
      while (prog_addr !== t && n < 200) begin
        @(negedge core_clk);
        n = n + 1;
      end
      chk16("pc_reached", t, prog_addr);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    #1;
    for (i = 0; i < 44; i = i + 1) u_exec_mem_model.pmem[i] = prog[i];
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    wait_pc(16'h000A);
    chk8("flags_cpi", 8'h35, status_flags);
    wait_pc(16'h0015);
    chk16("cycles", 16'h0017, cyc[15:0]);
    chk8("flags_cp", 8'h00, status_flags);
    wait_pc(16'h001C);
    chk8("flags_cp_low", 8'h15, status_flags);
    wait_pc(16'h002B);
    chk8("flags_cpc", 8'h35, status_flags);
    chk8("sram_0110", 8'h5A, u_exec_mem_model.dmem[9'h110]);
    chk8("sram_00ff", 8'h33, u_exec_mem_model.dmem[9'h0FF]);
    reg_chk("r16", 5'h10, 8'h5A);
    reg_chk("r17_pre_dec", 5'h11, 8'h5A);
    reg_chk("r18_copy", 5'h12, 8'h5A);
    reg_chk("r19_skips", 5'h13, 8'h33);
    reg_chk("r20_direct", 5'h14, 8'h5A);
    reg_chk("x_low", 5'h1A, 8'h10);
    reg_chk("x_high", 5'h1B, 8'h01);
    reg_chk("r21_disp", 5'h15, 8'h5A);
    reg_chk("r23_traps", 5'h17, 8'h00);
    reg_chk("r24_untaken", 5'h18, 8'h77);
    reg_chk("y_low", 5'h1C, 8'hFF);
    reg_chk("y_high", 5'h1D, 8'h00);
    reg_chk("z_low", 5'h1E, 8'h01);
    chk16("unknown_ops", 16'h0001, unsup[15:0]);
    stop_test;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (1000) @(posedge core_clk);
    fails = fails + 1;
    stop_test;
  end
endmodule
